//--- icr_regs.sv
// Interrupt controller register set, arbiter and pending-vector latch
//
// Added by the designer: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
module icr_regs
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [icr_pkg::ICR_NSRC-1:0] srcReq,
  input wire logic [2:0] extPin,
  input wire logic oscTrap,
  input wire logic stackTrap,
  input wire logic addrTrap,
  input wire logic mathTrap,
  input wire logic divZero,
  input wire logic disiActive,
  input wire logic cpuLevelWe,
  input wire logic [3:0] cpuLevelIn,
  output logic irqReq,
  output logic [6:0] irqVector,
  output logic [3:0] irqLevel,
  output logic [23:0] irqVecAddr,
  output logic [3:0] cpuLevel,
  output logic irq
);
  import icr_pkg::*;

  function automatic logic [15:0] laneMask(input logic [3:0] sel);
    laneMask = {{8{sel[1]}}, {8{sel[0]}}};
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] wd,
                                        input logic [3:0] sel);
    merge = (old & ~laneMask(sel)) | (wd & laneMask(sel));
  endfunction

  function automatic logic [23:0] tableAddr(input logic [6:0] vec,
                                            input logic alt);
    tableAddr = TABLE_BASE + {16'h0000, vec, 1'b0} +
                (alt ? ALT_TABLE_OFFSET : 24'h000000);
  endfunction

  logic [31:0] flag_r;
  logic [31:0] enable_r;
  logic [2:0] prio_r [ICR_NSRC];
  logic [2:0] lowLvl_r;
  logic levelMsb_r;
  logic [4:0] statusMisc_r;
  logic nestDis_r;
  logic [4:0] trap_r;
  logic altTable_r;
  logic [2:0] polarity_r;
  logic [6:0] pendVec_r;
  logic [3:0] pendLvl_r;
  logic [1:0] evtSt_r;
  logic [1:0] evtEn_r;
  logic [2:0] extMeta_r;
  logic [2:0] extSync_r;
  logic [2:0] extPrev_r;
  logic ack_r;
  logic [31:0] datOut_r;
  logic irqReq_r;
  logic [23:0] vecAddr_r;
  logic irq_r;

  logic busReq;
  logic wrReq;
  logic [15:0] wd;
  logic [15:0] rdData;
  logic [31:0] hwSet;
  logic [2:0] extEdge;
  logic [31:0] eligible;
  logic found;
  logic [4:0] bestIdx;
  logic [2:0] bestPri;
  logic [4:0] trapSet;
  logic [1:0] evtSet;
  logic evtAny;
  logic [2:0] prioSel;

  assign busReq = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wrReq = busReq & wb_we_i;
  assign wd = wb_dat_i[15:0];
  assign prioSel = 3'(wb_adr_i[4:2]);

  // Wishbone slave: one-cycle answer, write applied at acceptance
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      datOut_r <= 32'h00000000;
    end else begin
      ack_r <= busReq;
      if (busReq && !wb_we_i) begin
        datOut_r <= {16'h0000, rdData};
      end
    end
  end

  // Pins come from outside the clock domain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      extMeta_r <= 3'h0;
      extSync_r <= 3'h0;
      extPrev_r <= 3'h0;
    end else begin
      extMeta_r <= extPin;
      extSync_r <= extMeta_r;
      extPrev_r <= extSync_r;
    end
  end

  always_comb begin
    for (int k = 0; k < 3; k++) begin
      extEdge[k] = polarity_r[k] ? (extPrev_r[k] & ~extSync_r[k])
                                 : (~extPrev_r[k] & extSync_r[k]);
    end
    hwSet = srcReq;
    hwSet[EXT0_SRC] = srcReq[EXT0_SRC] | extEdge[0];
    hwSet[EXT1_SRC] = srcReq[EXT1_SRC] | extEdge[1];
    hwSet[EXT2_SRC] = srcReq[EXT2_SRC] | extEdge[2];
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 32'h00000000;
    end else begin
      flag_r <= (flag_r | hwSet) & SRC_IMPL_MASK;
      if (wrReq && wb_adr_i == OFF_FLAGS_ZERO) begin
        flag_r[15:0] <= (merge(flag_r[15:0], wd, wb_sel_i) |
                        hwSet[15:0]) & SRC_IMPL_MASK[15:0];
      end else if (wrReq && wb_adr_i == OFF_FLAGS_ONE) begin
        flag_r[31:16] <= (merge(flag_r[31:16], wd, wb_sel_i) |
                         hwSet[31:16]) & SRC_IMPL_MASK[31:16];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_r <= 32'h00000000;
    end else if (wrReq && wb_adr_i == OFF_ENABLE_ZERO) begin
      enable_r[15:0] <= merge(enable_r[15:0], wd, wb_sel_i) &
                        SRC_IMPL_MASK[15:0];
    end else if (wrReq && wb_adr_i == OFF_ENABLE_ONE) begin
      enable_r[31:16] <= merge(enable_r[31:16], wd, wb_sel_i) &
                         SRC_IMPL_MASK[31:16];
    end
  end

  // Four sources per priority register, three bits each
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < ICR_NSRC; i++) begin
        prio_r[i] <= SRC_IMPL_MASK[i] ? PRIO_RESET : 3'h0;
      end
    end else if (wrReq && wb_adr_i >= OFF_PRIO_BASE &&
                 wb_adr_i <= OFF_PRIO_LAST) begin
      for (int k = 0; k < 4; k++) begin
        if (wb_sel_i[k / 2] && SRC_IMPL_MASK[{prioSel, 2'(k)}]) begin
          prio_r[{prioSel, 2'(k)}] <= wd[4*k +: 3];
        end
      end
    end
  end

  // CPU level: core loads on entry and return, software limited
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lowLvl_r <= 3'h0;
      levelMsb_r <= 1'b0;
      statusMisc_r <= 5'h00;
    end else begin
      if (cpuLevelWe) begin
        lowLvl_r <= cpuLevelIn[2:0];
        levelMsb_r <= cpuLevelIn[3];
      end else begin
        if (wrReq && wb_adr_i == OFF_STATUS_WORD) begin
          if (wb_sel_i[0] && !nestDis_r) begin
            lowLvl_r <= wd[POS_LEVEL_LO +: 3];
          end
        end
        if (wrReq && wb_adr_i == OFF_CORE_CTRL && wb_sel_i[0] &&
            !wd[POS_LEVEL_MSB]) begin
          levelMsb_r <= 1'b0;
        end
      end
      if (wrReq && wb_adr_i == OFF_STATUS_WORD) begin
        if (wb_sel_i[0]) begin
          statusMisc_r[3:0] <= wd[3:0];
        end
        if (wb_sel_i[1]) begin
          statusMisc_r[4] <= wd[8];
        end
      end
    end
  end

  assign trapSet = {mathTrap, addrTrap, stackTrap, oscTrap, divZero};

  // Trap flags are sticky; a new trap beats the software clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nestDis_r <= 1'b0;
      trap_r <= 5'h00;
    end else begin
      trap_r <= trap_r | trapSet;
      if (wrReq && wb_adr_i == OFF_CTRL_ONE) begin
        if (wb_sel_i[1]) begin
          nestDis_r <= wd[POS_NEST_DIS];
        end
        if (wb_sel_i[0]) begin
          trap_r <= {wd[POS_MATH_TRAP], wd[POS_ADDR_TRAP],
                     wd[POS_STACK_TRAP], wd[POS_OSC_TRAP],
                     wd[POS_DIV_ZERO]} | trapSet;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      altTable_r <= 1'b0;
      polarity_r <= 3'h0;
    end else if (wrReq && wb_adr_i == OFF_CTRL_TWO) begin
      if (wb_sel_i[1]) begin
        altTable_r <= wd[POS_ALT_TABLE];
      end
      if (wb_sel_i[0]) begin
        polarity_r <= wd[2:0];
      end
    end
  end

  // Fixed arbitration: scanning downward, ties go to the lower index
  always_comb begin
    found = 1'b0;
    bestIdx = 5'h00;
    bestPri = 3'h0;
    for (int i = ICR_NSRC - 1; i >= 0; i--) begin
      eligible[i] = flag_r[i] & enable_r[i] & (prio_r[i] != 3'h0) &
                    ({1'b0, prio_r[i]} > {levelMsb_r, lowLvl_r}) &
                    ~levelMsb_r & (lowLvl_r != LEVEL_TOP);
      if (eligible[i] && (!found || prio_r[i] >= bestPri)) begin
        found = 1'b1;
        bestIdx = 5'(i);
        bestPri = prio_r[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqReq_r <= 1'b0;
      pendVec_r <= 7'h00;
      pendLvl_r <= 4'h0;
      vecAddr_r <= 24'h000000;
    end else begin
      irqReq_r <= found;
      if (found) begin
        pendVec_r <= FIRST_USER_VECTOR + {2'b00, bestIdx};
        pendLvl_r <= {1'b0, bestPri};
        vecAddr_r <= tableAddr(FIRST_USER_VECTOR + {2'b00, bestIdx},
                               altTable_r);
      end
    end
  end

  assign evtSet = {found & ~irqReq_r, |trapSet};
  assign evtAny = |(evtSt_r & evtEn_r);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evtSt_r <= 2'h0;
      evtEn_r <= 2'h0;
      irq_r <= 1'b0;
    end else begin
      if (wrReq && wb_adr_i == OFF_EVT_CLEAR && wb_sel_i[0]) begin
        evtSt_r <= (evtSt_r & ~wd[1:0]) | evtSet;
      end else begin
        evtSt_r <= evtSt_r | evtSet;
      end
      if (wrReq && wb_adr_i == OFF_EVT_ENABLE && wb_sel_i[0]) begin
        evtEn_r <= wd[1:0];
      end
      irq_r <= evtAny;
    end
  end

  always_comb begin
    rdData = 16'h0000;
    case (wb_adr_i)
      OFF_STATUS_WORD: begin
        rdData = {7'h00, statusMisc_r[4], lowLvl_r, 1'b0,
                  statusMisc_r[3:0]};
      end
      OFF_CORE_CTRL: rdData = {12'h000, levelMsb_r, 3'h0};
      OFF_CTRL_ONE: begin
        rdData = {nestDis_r, 8'h00, trap_r[0], 1'b0, trap_r[4:1],
                  1'b0};
      end
      OFF_CTRL_TWO: rdData = {altTable_r, disiActive, 11'h000, polarity_r};
      OFF_FLAGS_ZERO: rdData = flag_r[15:0];
      OFF_FLAGS_ONE: rdData = flag_r[31:16];
      OFF_ENABLE_ZERO: rdData = enable_r[15:0];
      OFF_ENABLE_ONE: rdData = enable_r[31:16];
      OFF_PENDING: rdData = {4'h0, pendLvl_r, 1'b0, pendVec_r};
      OFF_EVT_STATUS: rdData = {14'h0000, evtSt_r};
      OFF_EVT_ENABLE: rdData = {14'h0000, evtEn_r};
      default: begin
        if (wb_adr_i >= OFF_PRIO_BASE && wb_adr_i <= OFF_PRIO_LAST &&
            wb_adr_i[1:0] == 2'b00) begin
          for (int k = 0; k < 4; k++) begin
            rdData[4*k +: 3] = prio_r[{prioSel, 2'(k)}];
          end
        end
      end
    endcase
  end

  assign wb_dat_o = datOut_r;
  assign wb_ack_o = ack_r;
  assign irqReq = irqReq_r;
  assign irqVector = pendVec_r;
  assign irqLevel = pendLvl_r;
  assign irqVecAddr = vecAddr_r;
  assign cpuLevel = {levelMsb_r, lowLvl_r};
  assign irq = irq_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_latency: assert property (busReq |=> wb_ack_o)
    else $error("ack not given one cycle after request");
  chk_flag_hw_set: assert property (srcReq[1] |=> flag_r[1])
    else $error("hardware request did not set flag");
  chk_flag_sticky: assert property (flag_r[1] && !srcReq[1] &&
      !(wrReq && wb_adr_i == OFF_FLAGS_ZERO) |=> flag_r[1])
    else $error("flag cleared without a software write");
  chk_enable_gate: assert property (!(|(flag_r & enable_r))
      |=> !irqReq)
    else $error("request presented without enabled flag");
  chk_level_nonzero: assert property (irqReq |-> irqLevel != 4'h0
      && irqLevel[3] == 1'b0)
    else $error("presented level out of user range");
  chk_msb_block: assert property (levelMsb_r |=> !irqReq)
    else $error("user request passed with level msb set");
  chk_msb_no_set: assert property (!levelMsb_r && !cpuLevelWe
      |=> !levelMsb_r)
    else $error("software set the level msb");
  chk_nest_lock: assert property (nestDis_r && !cpuLevelWe
      |=> $stable(lowLvl_r))
    else $error("low level changed with nesting disabled");
  chk_vector_range: assert property (irqReq |->
      irqVector >= 7'h08 && irqVector <= 7'h27)
    else $error("pending vector outside user range");
  chk_alt_select: assert property (irqReq |->
      irqVecAddr[8] == $past(altTable_r))
    else $error("vector address ignores table select");
  chk_irq_level: assert property (##1 irq == $past(evtAny))
    else $error("interrupt output does not track status");

  cov_request: cover property (found ##1 irqReq);
  cov_alt_fetch: cover property (irqReq && irqVecAddr[8]);
  cov_trap_flag: cover property (|trapSet ##1 |trap_r);
  cov_level_block: cover property (|(flag_r & enable_r) && levelMsb_r);
endmodule

//--- icr_pkg.sv
// Constants shared by the interrupt control and status register block
package icr_pkg;
  localparam int ICR_NSRC = 32;
  localparam int ICR_NPRIO_REGS = 8;
  // Register byte offsets on the 32-bit register bus
  localparam logic [7:0] OFF_STATUS_WORD = 8'h00;
  localparam logic [7:0] OFF_CORE_CTRL = 8'h04;
  localparam logic [7:0] OFF_CTRL_ONE = 8'h08;
  localparam logic [7:0] OFF_CTRL_TWO = 8'h0c;
  localparam logic [7:0] OFF_FLAGS_ZERO = 8'h10;
  localparam logic [7:0] OFF_FLAGS_ONE = 8'h14;
  localparam logic [7:0] OFF_ENABLE_ZERO = 8'h18;
  localparam logic [7:0] OFF_ENABLE_ONE = 8'h1c;
  localparam logic [7:0] OFF_PRIO_BASE = 8'h20;
  localparam logic [7:0] OFF_PRIO_LAST = 8'h3c;
  localparam logic [7:0] OFF_PENDING = 8'h40;
  localparam logic [7:0] OFF_EVT_STATUS = 8'h44;
  localparam logic [7:0] OFF_EVT_ENABLE = 8'h48;
  localparam logic [7:0] OFF_EVT_CLEAR = 8'h4c;
  // Field positions
  localparam int POS_LEVEL_LO = 5;
  localparam int POS_LEVEL_MSB = 3;
  localparam int POS_NEST_DIS = 15;
  localparam int POS_OSC_TRAP = 1;
  localparam int POS_STACK_TRAP = 2;
  localparam int POS_ADDR_TRAP = 3;
  localparam int POS_MATH_TRAP = 4;
  localparam int POS_DIV_ZERO = 6;
  localparam int POS_ALT_TABLE = 15;
  localparam int POS_DISABLE_INSTRUCTION_ACTIVE = 14;
  localparam int POS_PEND_LEVEL = 8;
  // Sources wired to the three external request pins
  localparam int EXT0_SRC = 0;
  localparam int EXT1_SRC = 20;
  localparam int EXT2_SRC = 29;
  // Implemented sources; the rest read as zero
  localparam logic [31:0] SRC_IMPL_MASK = 32'h20db3fef;
  localparam logic [2:0] PRIO_RESET = 3'h4;
  localparam logic [2:0] LEVEL_TOP = 3'h7;
  localparam logic [6:0] FIRST_USER_VECTOR = 7'h08;
  localparam logic [23:0] TABLE_BASE = 24'h000004;
  localparam logic [23:0] ALT_TABLE_OFFSET = 24'h000100;
  localparam int EVT_TRAP = 0;
  localparam int EVT_NEW_REQ = 1;
endpackage

//--- icr_partner.sv
// Behavioural model of the core and of the requesting peripherals
`timescale 1ns/100ps
module icr_partner
  import icr_pkg::*;
(
  input wire logic clk,
  output logic [icr_pkg::ICR_NSRC-1:0] srcReq,
  output logic [2:0] extPin,
  output logic [4:0] trapEvt,
  output logic cpuLevelWe,
  output logic [3:0] cpuLevelIn
);
  initial begin
    srcReq = '0;
    extPin = 3'h0;
    trapEvt = 5'h00;
    cpuLevelWe = 1'b0;
    cpuLevelIn = 4'h0;
  end

  // One-cycle request pulse, as a peripheral raises it
  task automatic pulse_src(input int n);
    @(posedge clk);
    srcReq[n] <= 1'b1;
    @(posedge clk);
    srcReq <= '0;
  endtask

  // Trap order: osc, stack, addr, math, divide
  task automatic pulse_trap(input logic [4:0] t);
    @(posedge clk);
    trapEvt <= t;
    @(posedge clk);
    trapEvt <= 5'h00;
  endtask

  // Pins are asynchronous in real life; driven on the edge here
  task automatic set_pin(input int k, input logic v);
    @(posedge clk);
    extPin[k] <= v;
  endtask

  task automatic load_level(input logic [3:0] l);
    @(posedge clk);
    cpuLevelWe <= 1'b1;
    cpuLevelIn <= l;
    @(posedge clk);
    cpuLevelWe <= 1'b0;
  endtask
endmodule

//--- tb_icr_regs.sv
// Register-level testbench for the interrupt control block
`timescale 1ns/100ps
module tb_icr_regs;
  import icr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] datO;
  logic [31:0] rdat;
  logic ack;
  logic disiActive = 1'b0;
  logic [31:0] srcReq;
  logic [2:0] extPin;
  logic [4:0] trapEvt;
  logic cpuLevelWe;
  logic [3:0] cpuLevelIn;
  logic irqReq;
  logic [6:0] irqVector;
  logic [3:0] irqLevel;
  logic [23:0] irqVecAddr;
  logic [3:0] cpuLevel;
  logic irq;
  int n_fail = 0;
  int n_compared = 0;
  int trapBit[5] = '{1, 2, 3, 4, 6};

  always #12.5 clk = ~clk;

  icr_partner i_partner (.clk(clk), .srcReq(srcReq), .extPin(extPin),
    .trapEvt(trapEvt), .cpuLevelWe(cpuLevelWe), .cpuLevelIn(cpuLevelIn));

  icr_regs i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(datO), .wb_ack_o(ack), .srcReq(srcReq), .extPin(extPin),
    .oscTrap(trapEvt[0]), .stackTrap(trapEvt[1]), .addrTrap(trapEvt[2]),
    .mathTrap(trapEvt[3]), .divZero(trapEvt[4]), .disiActive(disiActive),
    .cpuLevelWe(cpuLevelWe), .cpuLevelIn(cpuLevelIn), .irqReq(irqReq),
    .irqVector(irqVector), .irqLevel(irqLevel), .irqVecAddr(irqVecAddr),
    .cpuLevel(cpuLevel), .irq(irq));

  task summarize;
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Ack and data taken at the rising edge that sees ack; released there
  task bus(input logic w, input logic [7:0] a, input logic [15:0] d,
           input logic [3:0] s);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (n >= 40) begin
      n_fail++;
      $display("unexpected at %0t: no bus answer", $time);
    end
    rdat = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d, 4'h3);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 16'h0000, 4'h3);
    chk(rdat, exp);
  endtask

  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  function automatic logic [31:0] prio_reset(input int r);
    logic [31:0] v;
    v = 32'h0;
    for (int k = 0; k < 4; k++) begin
      if (SRC_IMPL_MASK[4*r+k]) v[4*k+:3] = 3'h4;
    end
    return v;
  endfunction

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("unexpected at %0t: run did not finish", $time);
    summarize();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(OFF_STATUS_WORD + 8'(4*i), 32'h0);
      rd(OFF_PRIO_BASE + 8'(4*i), prio_reset(i));
    end
    rd(OFF_PENDING, 32'h0);
    bus(1'b1, OFF_PRIO_BASE, 16'h7777, 4'h1);
    rd(OFF_PRIO_BASE, 32'h4477);
    wr(8'h50, 16'hffff);
    rd(8'h50, 32'h0);
    i_partner.pulse_src(1);
    i_partner.pulse_src(4);
    i_partner.pulse_src(16);
    rd(OFF_FLAGS_ZERO, 32'h2);
    rd(OFF_FLAGS_ONE, 32'h1);
    wr(OFF_FLAGS_ONE, 16'h0000);
    tick(3);
    chk(irqReq, 1'b0);
    wr(OFF_ENABLE_ZERO, 16'h0006);
    wr(OFF_PRIO_BASE, 16'h4554);
    tick(3);
    chk({irqReq, irqVector, irqLevel}, {1'b1, 7'h09, 4'h5});
    chk(irqVecAddr, 24'h000016);
    rd(OFF_PENDING, 32'h0509);
    i_partner.pulse_src(2);
    tick(3);
    chk(irqVector, 7'h09);
    wr(OFF_PRIO_BASE, 16'h4504);
    tick(3);
    chk({irqVector, irqVecAddr}, {7'h0a, 24'h000018});
    wr(OFF_CTRL_TWO, 16'h8000);
    tick(3);
    chk(irqVecAddr, 24'h000118);
    wr(OFF_STATUS_WORD, 16'h00a0);
    tick(3);
    chk({irqReq, cpuLevel}, {1'b0, 4'h5});
    rd(OFF_STATUS_WORD, 32'h00a0);
    wr(OFF_STATUS_WORD, 16'h0080);
    tick(3);
    chk(irqReq, 1'b1);
    wr(OFF_PRIO_BASE, 16'h4704);
    wr(OFF_STATUS_WORD, 16'h00e0);
    tick(3);
    chk(irqReq, 1'b0);
    wr(OFF_STATUS_WORD, 16'h0000);
    i_partner.load_level(4'h8);
    tick(3);
    chk({irqReq, cpuLevel}, {1'b0, 4'h8});
    wr(OFF_CORE_CTRL, 16'h0000);
    rd(OFF_CORE_CTRL, 32'h0);
    wr(OFF_CORE_CTRL, 16'h0008);
    rd(OFF_CORE_CTRL, 32'h0);
    wr(OFF_CTRL_ONE, 16'h8000);
    wr(OFF_STATUS_WORD, 16'h0060);
    rd(OFF_STATUS_WORD, 32'h0);
    rd(OFF_CTRL_ONE, 32'h8000);
    wr(OFF_CTRL_ONE, 16'h0000);
    for (int k = 0; k < 5; k++) begin
      i_partner.pulse_trap(5'(1 << k));
      rd(OFF_CTRL_ONE, 32'(1 << trapBit[k]));
      wr(OFF_CTRL_ONE, 16'h0000);
    end
    // Event status carries earlier new-request events; wipe first
    wr(OFF_EVT_CLEAR, 16'h0003);
    wr(OFF_EVT_ENABLE, 16'h0001);
    i_partner.pulse_trap(5'h01);
    tick(3);
    chk(irq, 1'b1);
    wr(OFF_EVT_ENABLE, 16'h0000);
    tick(3);
    chk(irq, 1'b0);
    wr(OFF_EVT_ENABLE, 16'h0001);
    wr(OFF_EVT_CLEAR, 16'h0001);
    tick(3);
    chk(irq, 1'b0);
    rd(OFF_EVT_CLEAR, 32'h0);
    wr(OFF_FLAGS_ZERO, 16'h0000);
    i_partner.set_pin(0, 1'b1);
    tick(6);
    rd(OFF_FLAGS_ZERO, 32'h1);
    wr(OFF_FLAGS_ZERO, 16'h0000);
    wr(OFF_CTRL_TWO, 16'h0001);
    disiActive <= 1'b1;
    i_partner.set_pin(0, 1'b0);
    tick(6);
    rd(OFF_FLAGS_ZERO, 32'h1);
    rd(OFF_CTRL_TWO, 32'h4001);
    summarize();
  end
endmodule
